// file: hw/atp_pkg.sv
package atp_pkg;

	// ----------------------------------------
	// bus and register map
	// ----------------------------------------
	localparam int ADDR_W = 12; // apb byte address width
	localparam logic [7:0] IDX_PIN_SEL = 8'hDE; // pwm_pin_function_select
	localparam logic [7:0] IDX_PWM_MODE = 8'hDF; // pwm_mode_and_prescale
	localparam logic [7:0] IDX_TRIG_CFG = 8'hE1; // converter_trigger_config
	localparam logic [7:0] IDX_CONV_CTRL = 8'hF0; // start/busy and source select
	localparam logic [7:0] IDX_TRIG_DLY = 8'hF1; // nine-bit trigger delay
	localparam logic [1:0] WORD_LSBS = 2'h0; // byte address is index times four
	localparam logic [7:0] RST_BYTE = 8'h00; // reset value of every register
	localparam logic [8:0] RST_DLY = 9'h000; // reset value of the delay count

	// ----------------------------------------
	// writable bits of each register
	// ----------------------------------------
	localparam logic [7:0] MASK_PIN_SEL = 8'h3F;
	localparam logic [7:0] MASK_PWM_MODE = 8'hFF;
	localparam logic [7:0] MASK_TRIG_CFG = 8'h4F;
	localparam logic [7:0] MASK_CONV_CTRL = 8'h31;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int PRESC_LSB = 0; // pwm_clock_prescale [2:0]
	localparam int PRESC_W = 3;
	localparam int BRAKE_BIT = 3; // brake_input_enable
	localparam int ALIGN_BIT = 4; // pwm_alignment_kind
	localparam int GROUP_BIT = 5; // group_duty_enable
	localparam int KIND_LSB = 6; // pwm_operating_kind [7:6]
	localparam int POWER_BIT = 0; // converter_power_enable
	localparam int EXT_BIT = 1; // external_trigger_enable
	localparam int TYPE_LSB = 2; // trigger_type [3:2]
	localparam int SWAP_BIT = 6; // start_pin_swap
	localparam int BUSY_BIT = 0; // conversion_start_busy
	localparam int SRC_LSB = 4; // trigger_source_select [5:4]
	localparam int DLY_W = 9; // trigger_delay_count width
	localparam logic ALIGN_CENTER = 1'b1; // alignment code of centre-aligned type

	// ----------------------------------------
	// pin map: chan 5,4,3 on port 0, chan 2,1,0 on port 1
	// ----------------------------------------
	localparam int P0_PIN_CH5 = 3;
	localparam int P0_PIN_CH4 = 1;
	localparam int P0_PIN_CH3 = 0;
	localparam int P1_PIN_CH2 = 0;
	localparam int P1_PIN_CH1 = 1;
	localparam int P1_PIN_CH0 = 2;
	localparam int P0_PIN_START = 4; // start input, swap clear
	localparam int P1_PIN_START = 3; // start input, swap set

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		TT_FALL = 2'b00,
		TT_RISE = 2'b01,
		TT_CENTER = 2'b10,
		TT_END = 2'b11
	} atp_trig_type_e;

	typedef enum logic [1:0] {
		SRC_PWM0 = 2'b00,
		SRC_PWM2 = 2'b01,
		SRC_PWM4 = 2'b10,
		SRC_PIN = 2'b11
	} atp_src_e;

	typedef enum logic [1:0] {
		CS_IDLE = 2'b00,
		CS_DELAY = 2'b01,
		CS_BUSY = 2'b10
	} atp_conv_state_e;

	typedef struct packed {
		logic [15:0] pair2;
		logic [15:0] pair1;
		logic [15:0] pair0;
	} atp_duty_s;

	typedef struct packed {
		logic [7:0] port1;
		logic [7:0] port0;
	} atp_port_s;

endpackage

// file: hw/atp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for pad inputs
module atp_sync
	import atp_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta; // first stage, read only by second
		logic [WIDTH-1:0] stable; // second stage
	} atp_sync_s;

	atp_sync_s st;
	atp_sync_s next_st;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		next_st = st;
		if (clk_en)
		begin
			next_st.meta = async_in;
			next_st.stable = st.meta;
		end
	end

	// registers, constant under reset
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign sync_out = st.stable;

endmodule
`default_nettype wire

// file: hw/atp_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
// pwm clock prescaler: one tick every 2^div cycles
module atp_prescaler
	import atp_pkg::*;
#(
	parameter int CNT_W = 7
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic [PRESC_W-1:0] div,
	output logic tick
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt; // free count within one period
	} atp_presc_s;

	atp_presc_s st;
	atp_presc_s next_st;
	logic [CNT_W-1:0] mask; // low bits that must all be set

	// ----------------------------------------
	// tick decode and count
	// ----------------------------------------
	always_comb
	begin
		mask = CNT_W'((1 << div) - 1);
		tick = clk_en && ((st.cnt | ~mask) == {CNT_W{1'b1}});
		next_st = st;
		if (clk_en)
		begin
			if (tick)
				next_st.cnt = '0;
			else
				next_st.cnt = st.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end

endmodule
`default_nettype wire

// file: hw/atp_top.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// - sel bits 5..3 route chan 5,4,3 to port0
// - sel bits 2..0 route chan 2,1,0 to port1
// - group mode shares pair-zero duty
// - prescale divides pwm clock by 2^code
// - swap bit picks start pin
// - start pin swap takes effect at once
// - trigger type selects edge, centre or end
// - centre/end events only in centre-aligned mode
// - external off: software start only
// - external on: software or selected event
// - external triggers dropped while busy
// - enable bit powers converter
// - trigger config resets to zero
// - pin select and pwm control reset zero
// - nine-bit delay before triggered conversion
module atp_top
	import atp_pkg::*;
#(
	parameter int PRESC_CNT_W = 7
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// apb slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pwm generator side
	input wire logic [5:0] pwm_chan,
	input wire logic pwm_center_evt,
	input wire logic pwm_end_evt,
	input wire atp_duty_s pair_duty,
	output atp_duty_s pair_duty_eff,
	output logic group_duty_enable,
	output logic pwm_clk_tick,
	output logic [1:0] pwm_operating_kind,
	output logic pwm_alignment_kind,
	output logic brake_input_enable,
	// converter core side
	input wire logic conv_done,
	output logic conv_start,
	output logic conversion_start_busy,
	output logic converter_power_enable,
	// port logic side
	input wire atp_port_s gpio_out,
	input wire atp_port_s gpio_oe,
	output atp_port_s gpio_in,
	// pads
	input wire atp_port_s pad_in,
	output atp_port_s pad_out,
	output atp_port_s pad_oe
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] pin_sel; // pwm_pin_function_select
		logic [7:0] pwm_mode; // pwm_mode_and_prescale
		logic [7:0] trig_cfg; // converter_trigger_config
		logic [1:0] src; // trigger_source_select
		logic [DLY_W-1:0] dly; // trigger_delay_count
		atp_conv_state_e conv; // conversion sequencer
		logic [DLY_W-1:0] dly_cnt; // remaining delay cycles
		logic src_prev; // previous sample of trigger source
		logic start; // start pulse to converter
		atp_duty_s duty; // effective duties
		logic [31:0] rdata; // read data latched at setup
	} atp_state_s;

	atp_state_s st;
	atp_state_s next_st;
	atp_port_s pad_sync; // synchronised pad levels
	logic wr_en; // apb write in access phase
	logic rd_setup; // apb read in setup phase
	logic mapped; // address hits a register
	logic [7:0] idx; // word index of the access
	logic start_pin; // selected external start level
	logic src_level; // selected edge source level
	logic edge_evt; // qualifying edge seen
	logic period_evt; // qualifying period event
	logic ext_trig; // accepted-to-consider external trigger
	logic sw_start; // software start write
	atp_trig_type_e ttype; // decoded trigger type

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	atp_sync #(
		.WIDTH(16)
	) u_pad_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.async_in(pad_in),
		.sync_out(pad_sync)
	);

	atp_prescaler #(
		.CNT_W(PRESC_CNT_W)
	) u_presc (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.div(st.pwm_mode[PRESC_LSB +: PRESC_W]),
		.tick(pwm_clk_tick)
	);

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	always_comb
	begin
		idx = paddr[9:2];
		mapped = (paddr[1:0] == WORD_LSBS) && (paddr[ADDR_W-1:10] == '0)
			&& ((idx == IDX_PIN_SEL) || (idx == IDX_PWM_MODE) || (idx == IDX_TRIG_CFG)
			|| (idx == IDX_CONV_CTRL) || (idx == IDX_TRIG_DLY));
		wr_en = psel && penable && pwrite && mapped && clk_en;
		rd_setup = psel && !penable && !pwrite && clk_en;
	end

	// zero-wait slave, error on unmapped word
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = st.rdata;

	// ----------------------------------------
	// trigger source selection
	// ----------------------------------------
	always_comb
	begin
		ttype = atp_trig_type_e'(st.trig_cfg[TYPE_LSB +: 2]);
		// swap applies combinationally to the synced pins
		if (st.trig_cfg[SWAP_BIT])
			start_pin = pad_sync.port1[P1_PIN_START];
		else
			start_pin = pad_sync.port0[P0_PIN_START];
		case (atp_src_e'(st.src))
			SRC_PWM0: src_level = pwm_chan[0];
			SRC_PWM2: src_level = pwm_chan[2];
			SRC_PWM4: src_level = pwm_chan[4];
			SRC_PIN: src_level = start_pin;
			default: src_level = start_pin;
		endcase
		// edge against registered sample, one pulse per edge
		case (ttype)
			TT_FALL: edge_evt = st.src_prev && !src_level;
			TT_RISE: edge_evt = !st.src_prev && src_level;
			default: edge_evt = 1'b0;
		endcase
		// period events only for centre-aligned generator
		case (ttype)
			TT_CENTER: period_evt = pwm_center_evt;
			TT_END: period_evt = pwm_end_evt;
			default: period_evt = 1'b0;
		endcase
		period_evt = period_evt && (st.pwm_mode[ALIGN_BIT] == ALIGN_CENTER);
		// external events count only with external mode on
		ext_trig = st.trig_cfg[EXT_BIT] && (edge_evt || period_evt);
		sw_start = wr_en && (idx == IDX_CONV_CTRL) && pstrb[0] && pwdata[BUSY_BIT];
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		next_st = st;
		if (clk_en)
		begin
			next_st.start = 1'b0;
			next_st.src_prev = src_level;
			// register writes, byte lane 0 only
			if (wr_en && pstrb[0])
			begin
				case (idx)
					IDX_PIN_SEL: next_st.pin_sel = pwdata[7:0] & MASK_PIN_SEL;
					IDX_PWM_MODE: next_st.pwm_mode = pwdata[7:0] & MASK_PWM_MODE;
					IDX_TRIG_CFG: next_st.trig_cfg = pwdata[7:0] & MASK_TRIG_CFG;
					IDX_CONV_CTRL: next_st.src = pwdata[SRC_LSB +: 2];
					IDX_TRIG_DLY: next_st.dly[7:0] = pwdata[7:0];
					default: next_st.pin_sel = st.pin_sel;
				endcase
			end
			// delay bit 8 on byte lane 1
			if (wr_en && pstrb[1] && (idx == IDX_TRIG_DLY))
				next_st.dly[DLY_W-1] = pwdata[8];
			// conversion sequencer
			case (st.conv)
				CS_IDLE:
				begin
					if (sw_start)
					begin
						next_st.start = 1'b1;
						next_st.conv = CS_BUSY;
					end
					else if (ext_trig && (st.dly == '0))
					begin
						next_st.start = 1'b1;
						next_st.conv = CS_BUSY;
					end
					else if (ext_trig)
					begin
						// wait the programmed count first
						next_st.dly_cnt = st.dly;
						next_st.conv = CS_DELAY;
					end
				end
				CS_DELAY:
				begin
					// further external triggers ignored while pending, software start begins at once
					if (sw_start || (st.dly_cnt <= DLY_W'(1)))
					begin
						next_st.start = 1'b1;
						next_st.conv = CS_BUSY;
					end
					else
						next_st.dly_cnt = st.dly_cnt - DLY_W'(1);
				end
				CS_BUSY:
				begin
					// external triggers dropped until done
					if (conv_done && !sw_start)
						next_st.conv = CS_IDLE;
					else if (conv_done)
						next_st.start = 1'b1; // set wins over clear
				end
				default: next_st.conv = CS_IDLE;
			endcase
			// group mode: pair-zero duty feeds first three pairs
			if (st.pwm_mode[GROUP_BIT])
			begin
				next_st.duty.pair0 = pair_duty.pair0;
				next_st.duty.pair1 = pair_duty.pair0;
				next_st.duty.pair2 = pair_duty.pair0;
			end
			else
				next_st.duty = pair_duty;
			// read data latched in setup phase
			if (rd_setup)
			begin
				next_st.rdata = '0;
				case (idx)
					IDX_PIN_SEL: next_st.rdata[7:0] = st.pin_sel;
					IDX_PWM_MODE: next_st.rdata[7:0] = st.pwm_mode;
					IDX_TRIG_CFG: next_st.rdata[7:0] = st.trig_cfg;
					IDX_CONV_CTRL:
					begin
						next_st.rdata[SRC_LSB +: 2] = st.src;
						next_st.rdata[BUSY_BIT] = (st.conv != CS_IDLE);
					end
					IDX_TRIG_DLY: next_st.rdata[DLY_W-1:0] = st.dly;
					default: next_st.rdata = '0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st.pin_sel <= RST_BYTE;
			st.pwm_mode <= RST_BYTE;
			st.trig_cfg <= RST_BYTE;
			st.src <= 2'h0;
			st.dly <= RST_DLY;
			st.conv <= CS_IDLE;
			st.dly_cnt <= RST_DLY;
			st.src_prev <= 1'b0;
			st.start <= 1'b0;
			st.duty <= '0;
			st.rdata <= '0;
		end
		else
			st <= next_st;
	end

	// ----------------------------------------
	// pin multiplexing
	// ----------------------------------------
	always_comb
	begin
		pad_out = gpio_out;
		pad_oe = gpio_oe;
		// selected pins carry pwm and always drive
		if (st.pin_sel[5])
		begin
			pad_out.port0[P0_PIN_CH5] = pwm_chan[5];
			pad_oe.port0[P0_PIN_CH5] = 1'b1;
		end
		if (st.pin_sel[4])
		begin
			pad_out.port0[P0_PIN_CH4] = pwm_chan[4];
			pad_oe.port0[P0_PIN_CH4] = 1'b1;
		end
		if (st.pin_sel[3])
		begin
			pad_out.port0[P0_PIN_CH3] = pwm_chan[3];
			pad_oe.port0[P0_PIN_CH3] = 1'b1;
		end
		if (st.pin_sel[2])
		begin
			pad_out.port1[P1_PIN_CH2] = pwm_chan[2];
			pad_oe.port1[P1_PIN_CH2] = 1'b1;
		end
		if (st.pin_sel[1])
		begin
			pad_out.port1[P1_PIN_CH1] = pwm_chan[1];
			pad_oe.port1[P1_PIN_CH1] = 1'b1;
		end
		if (st.pin_sel[0])
		begin
			pad_out.port1[P1_PIN_CH0] = pwm_chan[0];
			pad_oe.port1[P1_PIN_CH0] = 1'b1;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign gpio_in = pad_sync;
	assign pair_duty_eff = st.duty;
	assign group_duty_enable = st.pwm_mode[GROUP_BIT];
	assign pwm_operating_kind = st.pwm_mode[KIND_LSB +: 2];
	assign pwm_alignment_kind = st.pwm_mode[ALIGN_BIT];
	assign brake_input_enable = st.pwm_mode[BRAKE_BIT];
	assign conv_start = st.start;
	assign conversion_start_busy = (st.conv != CS_IDLE);
	assign converter_power_enable = st.trig_cfg[POWER_BIT];

endmodule
`default_nettype wire

// file: hw/atp_top_fix_note.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: test/atp_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// port checker for atp_top
// ----------------
module atp_checker
	import atp_pkg::*;
#(
	parameter int PRESC_CNT_W = 7
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pslverr,
	input wire logic [5:0] pwm_chan,
	input wire atp_duty_s pair_duty,
	input wire atp_duty_s pair_duty_eff,
	input wire logic group_duty_enable,
	input wire logic conv_done,
	input wire logic conv_start,
	input wire logic conversion_start_busy,
	input wire atp_port_s gpio_out,
	input wire atp_port_s gpio_oe,
	input wire atp_port_s pad_out,
	input wire atp_port_s pad_oe
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);
	// group mode: every pair takes pair zero's duty
	a_group_share: assert property (group_duty_enable && clk_en |=>
		pair_duty_eff == {3{$past(pair_duty.pair0)}}) else $error("group duty not shared");
	a_own_duty: assert property (!group_duty_enable && clk_en |=>
		pair_duty_eff == $past(pair_duty)) else $error("own duty not passed");
	// start requests are single pulses
	a_start_once: assert property (conv_start && clk_en |=> !conv_start)
		else $error("start longer than one cycle");
	a_start_busy: assert property (conv_start |-> conversion_start_busy)
		else $error("start without busy");
	// busy holds until the core reports done, no restart in the fifth cycle after a start while done stays low
	a_busy_hold: assert property (conversion_start_busy && !conv_done |=>
		conversion_start_busy) else $error("busy dropped early");
	a_no_retrig: assert property (conv_start && clk_en ##1 (!conv_done)[*4] |=> !conv_start)
		else $error("start while busy");
	// pads show either port data or the routed channel
	a_pad_ch5: assert property (pad_oe.port0[3] && !gpio_oe.port0[3] |->
		pad_out.port0[3] == pwm_chan[5]) else $error("pad of chan5 wrong");
	a_pad_ch0: assert property (pad_oe.port1[2] && !gpio_oe.port1[2] |->
		pad_out.port1[2] == pwm_chan[0]) else $error("pad of chan0 wrong");
	// undriven pad still shows port data
	a_pad_port: assert property (!pad_oe.port0[3] |->
		pad_out.port0[3] == gpio_out.port0[3]) else $error("port pad data wrong");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	c_start: cover property (conv_start);
	c_group: cover property (group_duty_enable);
	c_err: cover property (pslverr);
endmodule

bind atp_top atp_checker #(.PRESC_CNT_W(PRESC_CNT_W)) u_chk (.sys_clk, .resetn, .clk_en,
	.psel, .penable, .pslverr, .pwm_chan, .pair_duty, .pair_duty_eff, .group_duty_enable,
	.conv_done, .conv_start, .conversion_start_busy, .gpio_out, .pad_out,
	.gpio_oe, .pad_oe);
`default_nettype wire

// file: test/atp_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// converter core: done pulse lat+1 cycles after start
// ----------------
module atp_conv_model
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic conv_start,
	input wire logic [7:0] lat,
	output logic conv_done
);
	logic [7:0] cnt; // cycles left in conversion
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt <= 8'h00;
			conv_done <= 1'h0;
		end
		else
		begin
			conv_done <= (cnt == 8'h01);
			if (conv_start)
				cnt <= lat;
			else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
		end
	end
endmodule
`default_nettype wire

// file: test/test_atp_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_atp_top
	import atp_pkg::*;
;
	// ----------------
	// signals
	// ----------------
	logic sys_clk, resetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [5:0] pwm_chan;
	logic pwm_center_evt, pwm_end_evt, group_duty_enable, pwm_clk_tick;
	logic [1:0] pwm_operating_kind;
	logic pwm_alignment_kind, brake_input_enable;
	logic conv_done, conv_start, conversion_start_busy, converter_power_enable;
	logic [7:0] lat;
	atp_duty_s pair_duty, pair_duty_eff;
	atp_port_s gpio_out, gpio_oe, pad_in, pad_out, pad_oe, gpio_in;
	int mismatches, n_compared, starts, cyc, t_start;
	int pm[6] = '{10, 9, 8, 0, 1, 3}; // pad bit of chan 0..5

	atp_top dut (.sys_clk, .resetn, .clk_en, .paddr, .psel, .penable, .pwrite, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .pwm_chan, .pwm_center_evt, .pwm_end_evt,
		.pair_duty, .pair_duty_eff, .group_duty_enable, .pwm_clk_tick,
		.pwm_operating_kind, .pwm_alignment_kind, .brake_input_enable, .conv_done,
		.conv_start, .conversion_start_busy, .converter_power_enable, .gpio_out, .gpio_oe,
		.gpio_in, .pad_in, .pad_out, .pad_oe);
	atp_conv_model u_core (.sys_clk, .resetn, .conv_start, .lat, .conv_done);

	initial
	begin
		sys_clk = 1'h0;
		forever #20 sys_clk = ~sys_clk;
	end
	// count starts and stamp the latest one
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (conv_start === 1'h1)
		begin
			starts <= starts + 1;
			t_start <= cyc;
		end
	end
	// ----------------
	// helpers
	// ----------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {2'h0, idx, WORD_LSBS};
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		@(posedge sys_clk);
		while (pready !== 1'h1)
			@(posedge sys_clk);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		xfer(1'h1, idx, d, q, e);
	endtask
	task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		xfer(1'h0, idx, 32'h0, q, e);
		chk(nm, exp, q);
	endtask
	// one rise, one fall, one centre, one end event
	task automatic stim(input int p);
		if (p < 16) pad_in[p] <= 1'h1; else pwm_chan[p - 16] <= 1'h1;
		repeat (8) @(posedge sys_clk);
		if (p < 16) pad_in[p] <= 1'h0; else pwm_chan[p - 16] <= 1'h0;
		repeat (8) @(posedge sys_clk);
		pwm_center_evt <= 1'h1;
		@(posedge sys_clk);
		pwm_center_evt <= 1'h0;
		repeat (8) @(posedge sys_clk);
		pwm_end_evt <= 1'h1;
		@(posedge sys_clk);
		pwm_end_evt <= 1'h0;
		repeat (8) @(posedge sys_clk);
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------
	// scenarios
	// ----------------
	task automatic t_regs();
		logic [31:0] q;
		logic e;
		rdc("pin_sel", IDX_PIN_SEL, 32'h0);
		rdc("pwm_mode", IDX_PWM_MODE, 32'h0);
		rdc("trig_cfg", IDX_TRIG_CFG, 32'h0);
		xfer(1'h0, 8'h10, 32'h0, q, e);
		chk("unmapped", 32'h1, {q[30:0], e});
		wr(IDX_TRIG_CFG, 32'hFF);
		rdc("trig_cfg", IDX_TRIG_CFG, {24'h0, MASK_TRIG_CFG});
		chk("power", 32'h1, converter_power_enable);
		wr(IDX_TRIG_CFG, 32'h0);
		chk("power", 32'h0, converter_power_enable);
		wr(IDX_PIN_SEL, 32'hFF);
		rdc("pin_sel", IDX_PIN_SEL, {24'h0, MASK_PIN_SEL});
		wr(IDX_TRIG_DLY, 32'h1FF);
		rdc("delay", IDX_TRIG_DLY, 32'h1FF);
		wr(IDX_TRIG_DLY, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_pins();
		gpio_out <= 16'hFFFF;
		pad_in <= 16'h5AA5;
		for (int i = 0; i < 6; i++)
		begin
			// only the routed channel is low
			pwm_chan <= ~(6'h1 << i);
			wr(IDX_PIN_SEL, 32'h1 << i);
			@(negedge sys_clk);
			for (int j = 0; j < 6; j++)
			begin
				chk("pad", (i == j) ? 32'h0 : 32'h1, pad_out[pm[j]]);
				chk("pad_oe", (i == j) ? 32'h1 : 32'h0, pad_oe[pm[j]]);
			end
			@(posedge sys_clk);
		end
		chk("gpio_in", 32'h5AA5, gpio_in);
		wr(IDX_PIN_SEL, 32'h0);
		{gpio_out, pad_in, pwm_chan} <= '0;
		$display("test pins done");
	endtask
	task automatic t_presc();
		int n;
		for (int c = 0; c < 8; c++)
		begin
			wr(IDX_PWM_MODE, c);
			repeat (256) @(posedge sys_clk);
			n = 0;
			repeat (256)
			begin
				@(negedge sys_clk);
				if (pwm_clk_tick === 1'h1) n++;
			end
			chk("ticks", 256 >> c, n);
			@(posedge sys_clk);
		end
		pair_duty <= {16'h3333, 16'h2222, 16'h1111};
		wr(IDX_PWM_MODE, 32'h20);
		repeat (2) @(posedge sys_clk);
		chk("grp", {16'h1111, 16'h1111}, pair_duty_eff[47:16]);
		wr(IDX_PWM_MODE, 32'h0);
		repeat (2) @(posedge sys_clk);
		chk("own", {16'h3333, 16'h2222}, pair_duty_eff[47:16]);
		wr(IDX_PWM_MODE, 32'hD8);
		chk("mode", 32'h1E, {pwm_operating_kind, pwm_alignment_kind,
			brake_input_enable, group_duty_enable});
		$display("test pwm done");
	endtask
	task automatic t_trig();
		for (int a = 0; a < 2; a++)
			for (int t = 0; t < 4; t++)
			begin
				wr(IDX_PWM_MODE, a << 4);
				wr(IDX_TRIG_CFG, (t << 2) | 3);
				starts = 0;
				stim(16);
				chk("ext", (t < 2 || a == 1) ? 32'h1 : 32'h0, starts);
			end
		wr(IDX_TRIG_CFG, 32'h1);
		starts = 0;
		stim(16);
		wr(IDX_CONV_CTRL, 32'h1);
		repeat (4) @(posedge sys_clk);
		chk("sw_only", 32'h1, starts);
		lat <= 8'h3C;
		wr(IDX_TRIG_CFG, 32'h7);
		starts = 0;
		stim(16);
		stim(16);
		lat <= 8'h02;
		stim(16);
		chk("busy_drop", 32'h2, starts);
		$display("test trig done");
	endtask
	task automatic t_pin_start();
		// rising edge on channel 2, then channel 4
		for (int s = 1; s < 3; s++)
		begin
			wr(IDX_CONV_CTRL, s << 4);
			starts = 0;
			stim(16 + 2 * s);
			chk("src_pwm", 32'h1, starts);
		end
		wr(IDX_CONV_CTRL, 32'h30);
		starts = 0;
		stim(4);
		chk("pin0_4", 32'h1, starts);
		stim(11);
		chk("pin1_3", 32'h1, starts);
		pad_in[11] <= 1'h1;
		repeat (4) @(posedge sys_clk);
		wr(IDX_TRIG_CFG, 32'h47);
		repeat (4) @(posedge sys_clk);
		chk("swap_now", 32'h2, starts);
		pad_in[11] <= 1'h0;
		stim(4);
		chk("pin0_4", 32'h2, starts);
		wr(IDX_CONV_CTRL, 32'h0);
		wr(IDX_TRIG_DLY, 32'h14);
		wr(IDX_TRIG_CFG, 32'h7);
		pwm_chan[0] <= 1'h1;
		t_start = cyc;
		repeat (40) @(posedge sys_clk);
		chk("delay", 32'h1, (t_start >= cyc - 20) && (t_start <= cyc - 16));
		$display("test start pin done");
	endtask
	// ----------------
	// main sequence and watchdog
	// ----------------
	initial
	begin
		{resetn, psel, penable, pwrite, pwm_chan, pwm_center_evt, pwm_end_evt} = '0;
		{paddr, pwdata, pair_duty, gpio_out, gpio_oe, pad_in} = '0;
		clk_en = 1'h1;
		pstrb = 4'hF;
		lat = 8'h02;
		{mismatches, n_compared, starts, cyc, t_start} = '0;
		repeat (20) @(posedge sys_clk);
		resetn <= 1'h1;
		@(posedge sys_clk);
		t_regs();
		t_pins();
		t_presc();
		t_trig();
		t_pin_start();
		summarize();
	end
	initial
	begin
		repeat (30000) @(posedge sys_clk);
		mismatches++;
		summarize();
	end
endmodule
`default_nettype wire
